/* File: pfpp_regs.vh */
// Constants of the parallel flash program port: modes, register map, reset values
`ifndef PFPP_REGS_VH
`define PFPP_REGS_VH

// ----------------------------------------------------------------------------
// Decoded operating modes
// ----------------------------------------------------------------------------
`define PFPP_MODE_NONE 3'h0
`define PFPP_MODE_READ 3'h1
`define PFPP_MODE_ODIS 3'h2
`define PFPP_MODE_PROG 3'h3
`define PFPP_MODE_PVER 3'h4
`define PFPP_MODE_ERASE 3'h5
`define PFPP_MODE_EVER 3'h6
`define PFPP_MODE_INHIB 3'h7

// ----------------------------------------------------------------------------
// Memory geometry and security location
// ----------------------------------------------------------------------------
`define PFPP_MEM_AW 15
`define PFPP_MEM_DEPTH 32768
`define PFPP_SEC_ADDR 16'hffff
`define PFPP_ERASED_BYTE 8'hff
`define PFPP_LOCK_BIT 0
`define PFPP_TBL_INH_BIT 1
`define PFPP_SEC_RESET 8'hff
`define PFPP_INVALID_BYTE 8'h00

// ----------------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define PFPP_CTRL_OFF 8'h00
`define PFPP_STAT_OFF 8'h04
`define PFPP_PCNT_OFF 8'h08
`define PFPP_CTRL_EN_BIT 0
`define PFPP_CTRL_RESET 32'h0000_0001
`define PFPP_STAT_MODE_LSB 0
`define PFPP_STAT_BUSY_BIT 3
`define PFPP_STAT_LOCK_BIT 4
`define PFPP_STAT_TINH_BIT 5
`define PFPP_STAT_PMODE_BIT 6

`endif

/* File: pfpp_mem.v */
// Byte-wide code store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.vh"

module pfpp_mem (
    // Clock
    input wire core_clk,
    input wire clk_en,
    // Access
    input wire [`PFPP_MEM_AW-1:0] addr,
    input wire wr_en,
    input wire [7:0] wdata,
    output reg [7:0] rdata_r
);

    reg [7:0] mem [0:`PFPP_MEM_DEPTH-1];

    // Single port, read-before-write so program can merge old contents
    always @(posedge core_clk) begin
        if (clk_en) begin
            rdata_r <= mem[addr];
            if (wr_en) begin
                mem[addr] <= wdata;
            end
        end
    end

endmodule // pfpp_mem
`default_nettype wire

/* File: pfpp_port.v */
// Parallel flash program port: mode decode, program, erase, verify, security
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.vh"

// Functional notes
// - Programming modes need reset pin high, latch strobe low, store strobe high.
// - 16-bit address from two port groups; port zero is the data bus.
// - Read returns code or security byte; invalid data once lock bit is zero.
// - Output enable high means data bus is not driven.
// - Program only at program level, chip enable low, output enable high.
// - Program verify at program level, chip enable high, output enable low.
// - Erase sets all cells and security bits; needs erase select, 0ff data.
// - Erase verify at erase level, chip enable high, output enable low.
// - Both enables high inhibit program and erase at high voltage.
// - Security register reachable only in programming mode.
// - Security register sits at the top address 0ffff.
// - Security bits only go 1 to 0 by program, back to 1 by erase.
// - Lock bit zero blocks code memory and security register access; erase verify here still reads both.
// - Table read from external code with bit 1 zero reaches external only.
// - Table read from internal code may always reach internal memory.
// - Security bit 1 high places no table read restriction.
module pfpp_port (
    // Clock, reset, clock enable
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Mode strapping pins
    input wire reset_pin,
    input wire ale_pin,
    input wire program_store_strobe_n,
    // Control pins
    input wire erase_select_ctrl,
    input wire upper_addr_ctrl_a,
    input wire upper_addr_ctrl_b,
    input wire output_gate_ctrl,
    input wire chip_en_n,
    input wire out_en_n,
    // Supply pin level flags
    input wire external_access_pin,
    input wire program_level,
    input wire erase_level,
    // Address and data bus
    input wire [15:0] addr_pin,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    // Code table read arbitration
    input wire code_table_read,
    input wire table_exec_internal,
    input wire table_target_internal,
    output wire table_grant
);

    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_PMERGE = 2'd1;
    localparam ST_ERASE = 2'd2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] mode_prev_r;
    reg [7:0] sec_r;
    reg [15:0] op_addr_r;
    reg [7:0] op_data_r;
    reg [`PFPP_MEM_AW-1:0] sweep_r;
    reg [31:0] ctrl_r;
    reg [15:0] pcnt_r;
    reg [7:0] data_sel;
    reg [2:0] mode;
    reg [`PFPP_MEM_AW-1:0] mem_addr;
    reg mem_we;
    reg [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    wire prog_mode;
    wire lock_on;
    wire busy;
    wire is_sec_now;
    wire bus_req;
    wire out_mode;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function is_sec;
        input [15:0] a;
        begin
            is_sec = (a == `PFPP_SEC_ADDR);
        end
    endfunction

    // Mode entry needs the strap levels and software enable
    assign prog_mode = reset_pin & ~ale_pin & program_store_strobe_n
                     & ctrl_r[`PFPP_CTRL_EN_BIT];
    assign lock_on = ~sec_r[`PFPP_LOCK_BIT];
    assign busy = (state_r != ST_IDLE);
    assign is_sec_now = is_sec(addr_pin);

    // Mode decode from control pins and supply flags; upper controls must be low
    always @* begin
        mode = `PFPP_MODE_NONE;
        if (prog_mode && !upper_addr_ctrl_a && !upper_addr_ctrl_b && !output_gate_ctrl) begin
            if (erase_level) begin
                if (chip_en_n && out_en_n) begin
                    mode = `PFPP_MODE_INHIB;
                end else if (erase_select_ctrl && !chip_en_n && out_en_n) begin
                    mode = `PFPP_MODE_ERASE;
                end else if (erase_select_ctrl && chip_en_n && !out_en_n) begin
                    mode = `PFPP_MODE_EVER;
                end
            end else if (program_level) begin
                if (chip_en_n && out_en_n) begin
                    mode = `PFPP_MODE_INHIB;
                end else if (!erase_select_ctrl && !chip_en_n && out_en_n) begin
                    mode = `PFPP_MODE_PROG;
                end else if (!erase_select_ctrl && chip_en_n && !out_en_n) begin
                    mode = `PFPP_MODE_PVER;
                end
            end else if (external_access_pin && !erase_select_ctrl && !chip_en_n) begin
                mode = out_en_n ? `PFPP_MODE_ODIS : `PFPP_MODE_READ;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer: program merges old byte, erase sweeps the whole array
    // ------------------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        mem_addr = addr_pin[`PFPP_MEM_AW-1:0];
        mem_we = 1'b0;
        mem_wdata = op_data_r & mem_rdata;
        case (state_r)
            ST_IDLE: begin
                if (mode != mode_prev_r && mode == `PFPP_MODE_ERASE
                    && !addr_pin[0] && data_in == `PFPP_ERASED_BYTE) begin
                    state_nxt = ST_ERASE;
                end else if (mode != mode_prev_r && mode == `PFPP_MODE_PROG && !lock_on) begin
                    state_nxt = ST_PMERGE;
                end
            end
            ST_PMERGE: begin
                mem_addr = op_addr_r[`PFPP_MEM_AW-1:0];
                mem_we = ~is_sec(op_addr_r);
                state_nxt = ST_IDLE;
            end
            ST_ERASE: begin
                mem_addr = sweep_r;
                mem_we = 1'b1;
                mem_wdata = `PFPP_ERASED_BYTE;
                if (&sweep_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State, captured operands, security byte
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            mode_prev_r <= `PFPP_MODE_NONE;
            sec_r <= `PFPP_SEC_RESET;
            op_addr_r <= 16'h0000;
            op_data_r <= 8'h00;
            sweep_r <= {`PFPP_MEM_AW{1'b0}};
            pcnt_r <= 16'h0000;
        end else if (clk_en) begin
            state_r <= state_nxt;
            mode_prev_r <= mode;
            if (state_r == ST_IDLE) begin
                op_addr_r <= addr_pin;
                op_data_r <= data_in;
                sweep_r <= {`PFPP_MEM_AW{1'b0}};
            end
            if (state_r == ST_ERASE) begin
                sweep_r <= sweep_r + 1'b1;
                sec_r <= `PFPP_SEC_RESET;
            end
            // Security bits can only be cleared by programming
            if (state_r == ST_PMERGE) begin
                pcnt_r <= pcnt_r + 1'b1;
                if (is_sec(op_addr_r)) begin
                    sec_r <= sec_r & op_data_r;
                end
            end
        end
    end

    pfpp_mem u_mem (
        .core_clk(core_clk),
        .clk_en(clk_en),
        .addr(mem_addr),
        .wr_en(mem_we),
        .wdata(mem_wdata),
        .rdata_r(mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Data bus output
    // ------------------------------------------------------------------------
    // Memory data lags the address by one cycle, so the pin address is
    // assumed stable for two cycles before the byte is taken
    assign out_mode = (mode == `PFPP_MODE_READ) || (mode == `PFPP_MODE_PVER)
                    || (mode == `PFPP_MODE_EVER);

    always @* begin
        if (lock_on && mode != `PFPP_MODE_EVER) begin
            data_sel = `PFPP_INVALID_BYTE;
        end else if (is_sec_now) begin
            data_sel = sec_r;
        end else begin
            data_sel = mem_rdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else if (clk_en) begin
            data_out <= data_sel;
            data_oe_n <= ~(out_mode && !busy);
        end
    end

    // Table read: internal target refused only from external code with bit 1 low
    assign table_grant = code_table_read & (~table_target_internal | table_exec_internal
                       | sec_r[`PFPP_TBL_INH_BIT]);

    // ------------------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped reads return zero
    // ------------------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `PFPP_CTRL_RESET;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && wb_we_i) begin
                if (wb_adr_i == `PFPP_CTRL_OFF && wb_sel_i[0]) begin
                    ctrl_r <= {31'h0000_0000, wb_dat_i[`PFPP_CTRL_EN_BIT]};
                end
            end else if (bus_req) begin
                if (wb_adr_i == `PFPP_CTRL_OFF) begin
                    wb_dat_o <= ctrl_r;
                end else if (wb_adr_i == `PFPP_STAT_OFF) begin
                    wb_dat_o <= {25'h0000000, prog_mode, sec_r[`PFPP_TBL_INH_BIT],
                                 sec_r[`PFPP_LOCK_BIT], busy, mode};
                end else if (wb_adr_i == `PFPP_PCNT_OFF) begin
                    wb_dat_o <= {16'h0000, pcnt_r};
                end
            end
        end
    end

endmodule // pfpp_port
`default_nettype wire

/* File: pfpp_port_monitor.sv */
// Checker of the flash program port: bus handshake, data bus drive, table reads
`timescale 1ns/1ps
`default_nettype none
module pfpp_port_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Strap and control pins
    input wire logic reset_pin,
    input wire logic ale_pin,
    input wire logic program_store_strobe_n,
    input wire logic erase_select_ctrl,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic program_level,
    input wire logic erase_level,
    input wire logic data_oe_n,
    // Table read arbitration
    input wire logic code_table_read,
    input wire logic table_exec_internal,
    input wire logic table_target_internal,
    input wire logic table_grant
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Program verify decode; held three cycles so busy has drained
    wire logic strap = reset_pin & ~ale_pin & program_store_strobe_n;
    wire logic pver = strap & ~erase_select_ctrl & program_level & ~erase_level
        & chip_en_n & ~out_en_n;
    AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_NO_STRAP: assert property (!strap |=> data_oe_n)
        else $error("data bus driven outside programming mode");
    AST_OE_HIGH: assert property (out_en_n |=> data_oe_n)
        else $error("data bus driven with output enable high");
    AST_INHIBIT: assert property ((chip_en_n && out_en_n)[*2] |-> data_oe_n ##1 data_oe_n)
        else $error("data bus driven while inhibited");
    AST_PVER_DRIVE: assert property (pver[*3] |-> !data_oe_n)
        else $error("program verify does not drive");
    AST_GRANT_INT: assert property (code_table_read && table_exec_internal |-> table_grant)
        else $error("table read from internal code refused");
    AST_GRANT_IDLE: assert property (!code_table_read |-> !table_grant)
        else $error("grant without table read");
    // Main scenarios
    COV_PVER: cover property (pver[*3]);
    COV_ERASE: cover property (strap && erase_level && !chip_en_n);
    COV_DENY: cover property (code_table_read && !table_grant);
endmodule // pfpp_port_monitor
bind pfpp_port pfpp_port_monitor u_mon (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .reset_pin, .ale_pin, .program_store_strobe_n,
    .erase_select_ctrl, .chip_en_n, .out_en_n, .program_level, .erase_level,
    .data_oe_n, .code_table_read, .table_exec_internal, .table_target_internal,
    .table_grant);
`default_nettype wire

/* File: pfpp_prog_model.sv */
// Programmer model: turns an operation code into the pin levels of the table
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.vh"
module pfpp_prog_model (
    // Command from the bench
    input wire logic [2:0] op,
    input wire logic [7:0] d,
    input wire logic [7:0] data_out,
    // Pins toward the device
    output logic reset_pin,
    output logic ale_pin,
    output logic program_store_strobe_n,
    output logic erase_select_ctrl,
    output logic chip_en_n,
    output logic out_en_n,
    output logic external_access_pin,
    output logic program_level,
    output logic erase_level,
    output logic [7:0] data_in
);
    logic drv;
    // Straps held for every operation; none only drops the reset pin
    always_comb begin
        reset_pin = (op != `PFPP_MODE_NONE);
        ale_pin = 1'b0;
        program_store_strobe_n = 1'b1;
        erase_select_ctrl = (op == `PFPP_MODE_ERASE) || (op == `PFPP_MODE_EVER);
        chip_en_n = op inside {`PFPP_MODE_PVER, `PFPP_MODE_EVER, `PFPP_MODE_INHIB};
        out_en_n = op inside {`PFPP_MODE_ODIS, `PFPP_MODE_PROG, `PFPP_MODE_ERASE,
            `PFPP_MODE_INHIB};
        external_access_pin = 1'b1;
        program_level = op inside {`PFPP_MODE_PROG, `PFPP_MODE_PVER, `PFPP_MODE_INHIB};
        erase_level = (op == `PFPP_MODE_ERASE) || (op == `PFPP_MODE_EVER);
        drv = out_en_n;
        // Released bus shows the inverse of what the device last put out
        data_in = drv ? d : ~data_out;
    end
endmodule // pfpp_prog_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the flash program port
`timescale 1ns/1ps
`default_nettype none
`include "pfpp_regs.vh"
module testbench;
    logic core_clk = 0, rst_n = 0, clk_en = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic reset_pin, ale_pin, program_store_strobe_n, erase_select_ctrl;
    logic upper_addr_ctrl_a = 0, upper_addr_ctrl_b = 0, output_gate_ctrl = 0;
    logic chip_en_n, out_en_n, external_access_pin, program_level, erase_level;
    logic [15:0] addr_pin = 0;
    logic [7:0] data_in, data_out, pd = 0;
    logic [2:0] op = `PFPP_MODE_NONE;
    logic data_oe_n, code_table_read = 0, table_exec_internal = 0;
    logic table_target_internal = 0, table_grant;
    int err_total = 0, check_count = 0;
    pfpp_port dut (.core_clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pin, .ale_pin,
        .program_store_strobe_n, .erase_select_ctrl, .upper_addr_ctrl_a,
        .upper_addr_ctrl_b, .output_gate_ctrl, .chip_en_n, .out_en_n,
        .external_access_pin, .program_level, .erase_level, .addr_pin, .data_in,
        .data_out, .data_oe_n, .code_table_read, .table_exec_internal,
        .table_target_internal, .table_grant);
    pfpp_prog_model u_prog (.op, .d(pd), .data_out, .reset_pin, .ale_pin,
        .program_store_strobe_n, .erase_select_ctrl, .chip_en_n, .out_en_n,
        .external_access_pin, .program_level, .erase_level, .data_in);
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
        n = 0;
        do begin @(posedge core_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
        if (n >= 50) chk("ack", 0, 1);
    endtask
    task automatic pin(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        op <= o; addr_pin <= a; pd <= d;
        repeat (4) @(posedge core_clk);
    endtask
    // Program entered from idle, then verified at once
    task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
        pin(`PFPP_MODE_NONE, a, d);
        pin(`PFPP_MODE_PROG, a, d);
        pin(`PFPP_MODE_PVER, a, 0);
        chk("verify", {data_oe_n, data_out}, {1'b0, e});
    endtask
    task automatic t_regs;
        wb(0, `PFPP_CTRL_OFF, 0); chk("ctrl", q, `PFPP_CTRL_RESET);
        wb(0, 8'h40, 0); chk("unmapped", q, 0);
        wb(1, `PFPP_CTRL_OFF, 0); wb(0, `PFPP_CTRL_OFF, 0); chk("ctrl0", q, 0);
        wb(1, `PFPP_CTRL_OFF, 1);
        $display("test regs done");
    endtask
    task automatic t_erase;
        int n;
        pin(`PFPP_MODE_ERASE, 16'h0, 8'hff);
        n = 0;
        do begin wb(0, `PFPP_STAT_OFF, 0); n++; end while (q[3] !== 1'b0 && n < 20000);
        chk("erase_busy", q[3], 0);
        pin(`PFPP_MODE_EVER, 16'h7ffe, 0); chk("ever", data_out, 8'hff);
        pin(`PFPP_MODE_READ, `PFPP_SEC_ADDR, 0); chk("sec", data_out, 8'hff);
        $display("test erase done");
    endtask
    task automatic t_prog;
        prog(16'h5, 8'ha5, 8'ha5);
        prog(16'h5, 8'h0f, 8'h05);
        pin(`PFPP_MODE_ODIS, 16'h5, 0); chk("odis", data_oe_n, 1);
        // Upper address controls must stay low for any mode
        upper_addr_ctrl_a <= 1;
        pin(`PFPP_MODE_READ, 16'h5, 0); chk("upper", data_oe_n, 1);
        upper_addr_ctrl_a <= 0;
        pin(`PFPP_MODE_INHIB, 16'h6, 8'h00);
        pin(`PFPP_MODE_PVER, 16'h6, 0); chk("inhib", data_out, 8'hff);
        wb(0, `PFPP_PCNT_OFF, 0); chk("pcnt", q[15:0], 16'h2);
        $display("test program done");
    endtask
    task automatic t_table;
        code_table_read <= 1; table_target_internal <= 1;
        pin(`PFPP_MODE_NONE, 0, 0); chk("grant1", table_grant, 1);
        prog(`PFPP_SEC_ADDR, 8'hfd, 8'hfd);
        chk("grant0", table_grant, 0);
        table_exec_internal <= 1;
        pin(`PFPP_MODE_NONE, 0, 0); chk("grantint", table_grant, 1);
        $display("test table done");
    endtask
    task automatic t_lock;
        prog(`PFPP_SEC_ADDR, 8'hfe, `PFPP_INVALID_BYTE);
        pin(`PFPP_MODE_READ, 16'h5, 0); chk("locked", data_out, `PFPP_INVALID_BYTE);
        wb(0, `PFPP_STAT_OFF, 0); chk("stat", q[5:4], 2'b00);
        $display("test lock done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1;
        t_regs(); t_erase(); t_prog(); t_table(); t_lock();
        conclude();
    end
endmodule // testbench
`default_nettype wire
